// ==== pkg/dcar_pkg.sv ====
package dcar_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned            REG_ADDR_W          = 8;
    localparam int unsigned            REG_DATA_W          = 16;
    localparam logic [REG_ADDR_W-1:0]  CHAIN_ADDR_CFG_OFS  = 8'h01;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int unsigned            CHAIN_ADDR_W        = 5;
    localparam int unsigned            UNLOCK_BIT          = 15;
    localparam int unsigned            BOTTOM_LSB          = 10;
    localparam int unsigned            TOP_LSB             = 5;
    localparam int unsigned            OWN_LSB             = 0;

    // ------------------------------------------------------------------
    // Values after power-on reset, and the enumeration address step
    // ------------------------------------------------------------------
    localparam logic                   UNLOCK_RST          = 1'b1;
    localparam logic [4:0]             BOTTOM_RST          = 5'h00;
    localparam logic [4:0]             TOP_RST             = 5'h00;
    localparam logic [4:0]             OWN_RST             = 5'h00;
    localparam logic [4:0]             ADDR_STEP           = 5'h01;
    localparam logic [REG_DATA_W-1:0]  RDATA_RST           = 16'h0000;

    // ------------------------------------------------------------------
    // Serial mode select encoding
    // ------------------------------------------------------------------
    localparam logic                   MODE_CHAINED        = 1'b1;

endpackage : dcar_pkg

// ==== pkg/dcar_enum_if.sv ====
`timescale 1ns/1ns

interface dcar_enum_if;

    // Command towards the step logic.
    logic       cmdValid;
    logic       cmdUpPath;
    logic [4:0] cmdAddr;
    // Forwarded address back from the step logic.
    logic       fwdValid;
    logic [4:0] fwdAddr;

    modport ctrl
    (
        output cmdValid,
        output cmdUpPath,
        output cmdAddr,
        input  fwdValid,
        input  fwdAddr
    );

    modport step
    (
        input  cmdValid,
        input  cmdUpPath,
        input  cmdAddr,
        output fwdValid,
        output fwdAddr
    );

endinterface : dcar_enum_if

// ==== design/dcar_enum_step.sv ====
`timescale 1ns/1ns

module dcar_enum_step
(
    // Clock and power-on reset
    input  wire logic  clk_sys,
    input  wire logic  rst_b,
    // Enumeration command and forward path
    dcar_enum_if.step  enumBus
);

    // ------------------------------------------------------------------
    // Forward address computation
    // ------------------------------------------------------------------
    logic       fwdValid_d;
    logic       fwdValid_q;
    logic [4:0] fwdAddr_d;
    logic [4:0] fwdAddr_q;

    // The step wraps modulo 32; keeping the chain in range is the host's job.
    always_comb
    begin
        fwdValid_d = enumBus.cmdValid;
        fwdAddr_d  = fwdAddr_q;
        if (enumBus.cmdValid)
        begin
            if (enumBus.cmdUpPath)
            begin
                fwdAddr_d = enumBus.cmdAddr + dcar_pkg::ADDR_STEP;
            end
            else
            begin
                fwdAddr_d = enumBus.cmdAddr - dcar_pkg::ADDR_STEP;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fwdValid_q <= 1'b0;
            fwdAddr_q  <= dcar_pkg::OWN_RST;
        end
        else
        begin
            fwdValid_q <= fwdValid_d;
            fwdAddr_q  <= fwdAddr_d;
        end
    end

    assign enumBus.fwdValid = fwdValid_q;
    assign enumBus.fwdAddr  = fwdAddr_q;

endmodule : dcar_enum_step

// ==== design/dcar_address_reg.sv ====
// How it works
// - Register-port mode ignores all chain address contents.
// - Unlock bit powers up set, allowing re-enumeration.
// - Only enumeration clears unlock; zero writes ignored.
// - Software reset leaves unlock and addresses untouched.
// - Bottom, top, own addresses consistent across chain.
// - Up path: accept address, forward plus one.
// - Down path: accept address, forward minus one.
// - Own address changes only by unlocked enumeration.
`timescale 1ns/1ns

module dcar_address_reg
(
    // Clock and power-on reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Mode and software reset
    input  wire logic        serialModeSelect,
    input  wire logic        softwareResetRequest,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic [15:0] regWrData,
    input  wire logic        regRdEn,
    output logic      [15:0] regRdData,
    output logic             regRdValid,
    // Chain enumeration command in
    input  wire logic        enumCmdValid,
    input  wire logic        enumCmdUpPath,
    input  wire logic [4:0]  enumCmdAddr,
    // Chain enumeration command forwarded
    output logic             enumFwdValid,
    output logic      [4:0]  enumFwdAddr,
    // Addresses in use by the link logic
    output logic             chainAddrActive,
    output logic      [4:0]  bottomChainAddr,
    output logic      [4:0]  topChainAddr,
    output logic      [4:0]  ownChainAddr,
    output logic             addressWriteUnlock
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic chainMode;
    logic cfgHit;
    logic cfgWrite;
    logic cfgRead;
    logic enumTake;

    // In register-port mode the link logic must see neither the fields nor
    // any enumeration effect, so the command is dropped here at the source.
    assign chainMode = (serialModeSelect == dcar_pkg::MODE_CHAINED);
    assign cfgHit    = (regAddr == dcar_pkg::CHAIN_ADDR_CFG_OFS);
    assign cfgWrite  = regWrEn && cfgHit;
    assign cfgRead   = regRdEn;
    assign enumTake  = enumCmdValid && chainMode;

    // ------------------------------------------------------------------
    // Write field decode
    // ------------------------------------------------------------------
    logic       wrUnlockSet;
    logic [4:0] wrBottom;
    logic [4:0] wrTop;

    // Bits 4 to 0 of a write are never looked at: only enumeration moves
    // the own address.
    assign wrUnlockSet = regWrData[dcar_pkg::UNLOCK_BIT];
    assign wrBottom    = regWrData[dcar_pkg::BOTTOM_LSB +: dcar_pkg::CHAIN_ADDR_W];
    assign wrTop       = regWrData[dcar_pkg::TOP_LSB +: dcar_pkg::CHAIN_ADDR_W];

    // ------------------------------------------------------------------
    // Address fields
    // ------------------------------------------------------------------
    logic       unlock_d;
    logic       unlock_q;
    logic [4:0] bottom_d;
    logic [4:0] bottom_q;
    logic [4:0] top_d;
    logic [4:0] top_q;
    logic [4:0] own_d;
    logic [4:0] own_q;

    // The software reset request is deliberately not an input of this
    // process: only rst_b may restore the fields.
    always_comb
    begin
        unlock_d = unlock_q;
        bottom_d = bottom_q;
        top_d    = top_q;
        own_d    = own_q;
        if (enumTake)
        begin
            if (unlock_q)
            begin
                own_d = enumCmdAddr;
            end
            // A locked device keeps its address; forwarding still happens.
            unlock_d = 1'b0;
        end
        if (cfgWrite)
        begin
            // Bottom and top are plain fields for the host's broadcast write.
            bottom_d = wrBottom;
            top_d    = wrTop;
            // A one written in the same cycle as an enumeration wins.
            if (wrUnlockSet)
            begin
                unlock_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            unlock_q <= dcar_pkg::UNLOCK_RST;
            bottom_q <= dcar_pkg::BOTTOM_RST;
            top_q    <= dcar_pkg::TOP_RST;
            own_q    <= dcar_pkg::OWN_RST;
        end
        else
        begin
            unlock_q <= unlock_d;
            bottom_q <= bottom_d;
            top_q    <= top_d;
            own_q    <= own_d;
        end
    end

    // ------------------------------------------------------------------
    // Enumeration forward path
    // ------------------------------------------------------------------
    dcar_enum_if enumBus ();

    assign enumBus.cmdValid  = enumTake;
    assign enumBus.cmdUpPath = enumCmdUpPath;
    assign enumBus.cmdAddr   = enumCmdAddr;

    dcar_enum_step u_step
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .enumBus (enumBus)
    );

    assign enumFwdValid = enumBus.fwdValid;
    assign enumFwdAddr  = enumBus.fwdAddr;

    // ------------------------------------------------------------------
    // Register read return
    // ------------------------------------------------------------------
    logic [15:0] rdData_d;
    logic [15:0] rdData_q;
    logic        rdValid_d;
    logic        rdValid_q;
    logic [15:0] cfgWord;

    // Each field is placed by its package position, so the map lives in one place.
    always_comb
    begin
        cfgWord = dcar_pkg::RDATA_RST;
        cfgWord[dcar_pkg::UNLOCK_BIT] = unlock_q;
        cfgWord[dcar_pkg::BOTTOM_LSB +: dcar_pkg::CHAIN_ADDR_W] = bottom_q;
        cfgWord[dcar_pkg::TOP_LSB +: dcar_pkg::CHAIN_ADDR_W]    = top_q;
        cfgWord[dcar_pkg::OWN_LSB +: dcar_pkg::CHAIN_ADDR_W]    = own_q;
    end

    // A software reset drops only a pending read answer, never the fields.
    always_comb
    begin
        rdData_d  = rdData_q;
        rdValid_d = cfgRead && !softwareResetRequest;
        if (softwareResetRequest)
        begin
            rdData_d = dcar_pkg::RDATA_RST;
        end
        else if (cfgRead)
        begin
            rdData_d = cfgHit ? cfgWord : dcar_pkg::RDATA_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdData_q  <= dcar_pkg::RDATA_RST;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign regRdData  = rdData_q;
    assign regRdValid = rdValid_q;

    // ------------------------------------------------------------------
    // Addresses for the link logic
    // ------------------------------------------------------------------
    // The checker and error-check logic downstream trust these fields, so
    // they are presented as zero outside chained mode.
    assign chainAddrActive    = chainMode;

    // Defaults first, so a mode change never lets stale addresses through.
    always_comb
    begin
        bottomChainAddr = dcar_pkg::BOTTOM_RST;
        topChainAddr    = dcar_pkg::TOP_RST;
        ownChainAddr    = dcar_pkg::OWN_RST;
        if (chainMode)
        begin
            bottomChainAddr = bottom_q;
            topChainAddr    = top_q;
            ownChainAddr    = own_q;
        end
    end
    assign addressWriteUnlock = unlock_q;

endmodule : dcar_address_reg

// ==== sim/dcar_address_reg_assertions.sv ====
`timescale 1ns/1ns
module dcar_address_reg_assertions
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_b,
    // Enumeration
    input wire logic       serialModeSelect,
    input wire logic       enumCmdValid,
    input wire logic       enumCmdUpPath,
    input wire logic [4:0] enumCmdAddr,
    input wire logic       enumFwdValid,
    input wire logic [4:0] enumFwdAddr,
    // Fields
    input wire logic [4:0] ownChainAddr,
    input wire logic       addressWriteUnlock
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence s_cmd;
        enumCmdValid && serialModeSelect;
    endsequence
    a_own_hidden: assert property (!serialModeSelect |-> ownChainAddr == 5'h00)
        else $error("own shown");
    a_enum_ignored: assert property (enumCmdValid && !serialModeSelect |=> !enumFwdValid)
        else $error("enum taken");
    a_up_forward: assert property (s_cmd ##0 enumCmdUpPath |=>
        enumFwdValid && enumFwdAddr == $past(enumCmdAddr) + 5'h01) else $error("up fwd");
    a_down_forward: assert property (s_cmd ##0 !enumCmdUpPath |=>
        enumFwdValid && enumFwdAddr == $past(enumCmdAddr) - 5'h01) else $error("down fwd");
    a_own_taken: assert property (s_cmd ##0 addressWriteUnlock |=>
        !serialModeSelect || ownChainAddr == $past(enumCmdAddr)) else $error("own kept");
    a_own_kept: assert property ($changed(ownChainAddr) && $past(serialModeSelect) |->
        !serialModeSelect || $past(enumCmdValid && addressWriteUnlock)) else $error("own moved");
    a_unlock_clear: assert property ($fell(addressWriteUnlock) |->
        $past(enumCmdValid && serialModeSelect)) else $error("unlock fell");
    a_unlock_powerup: assert property ($rose(rst_b) |-> addressWriteUnlock)
        else $error("unlock low");
endmodule : dcar_address_reg_assertions

bind dcar_address_reg dcar_address_reg_assertions dcar_address_reg_assertions_i
(
    .clk_sys(clk_sys), .rst_b(rst_b), .serialModeSelect(serialModeSelect),
    .enumCmdValid(enumCmdValid), .enumCmdUpPath(enumCmdUpPath), .enumCmdAddr(enumCmdAddr),
    .enumFwdValid(enumFwdValid), .enumFwdAddr(enumFwdAddr), .ownChainAddr(ownChainAddr),
    .addressWriteUnlock(addressWriteUnlock)
);

// ==== sim/dcar_host_model.sv ====
`timescale 1ns/1ns
module dcar_host_model
(
    // Clock
    input  wire logic       clk_sys,
    // Command towards the device
    output logic            enumCmdValid = 1'b0,
    output logic            enumCmdUpPath = 1'b0,
    output logic      [4:0] enumCmdAddr = 5'h00,
    // Forward from the device
    input  wire logic       enumFwdValid,
    input  wire logic [4:0] enumFwdAddr
);
    // Start addresses keep the chain inside 0x00 to 0x1F.
    task send(input logic up, input logic [4:0] a, output logic v, output logic [4:0] f);
        @(posedge clk_sys);
        enumCmdValid <= 1'b1;
        enumCmdUpPath <= up;
        enumCmdAddr <= a;
        @(posedge clk_sys);
        enumCmdValid <= 1'b0;
        // An idle line shows garbage, so a design that reads it late is caught.
        enumCmdAddr <= ~a;
        #1;
        v = enumFwdValid;
        f = enumFwdAddr;
    endtask : send
endmodule : dcar_host_model

// ==== sim/dcar_address_reg_tb_top.sv ====
`timescale 1ns/1ns
module dcar_address_reg_tb_top;
    logic        clk_sys;
    logic        rst_b;
    logic        serialModeSelect;
    logic        softwareResetRequest;
    logic [7:0]  regAddr;
    logic        regWrEn;
    logic [15:0] regWrData;
    logic        regRdEn;
    logic [15:0] regRdData;
    logic        regRdValid;
    logic        enumCmdValid;
    logic        enumCmdUpPath;
    logic [4:0]  enumCmdAddr;
    logic        enumFwdValid;
    logic [4:0]  enumFwdAddr;
    logic [4:0]  ownChainAddr;
    logic        chainAddrActive;
    logic [4:0]  bottomChainAddr;
    logic [4:0]  topChainAddr;
    logic        addressWriteUnlock;
    logic        fwdValid;
    logic [4:0]  fwdAddr;
    int          fail_count = 0;
    int          n_checks = 0;
    dcar_address_reg dcar_address_reg_i
    (
        .clk_sys(clk_sys), .rst_b(rst_b), .serialModeSelect(serialModeSelect),
        .softwareResetRequest(softwareResetRequest), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .enumCmdValid(enumCmdValid), .enumCmdUpPath(enumCmdUpPath),
        .enumCmdAddr(enumCmdAddr), .enumFwdValid(enumFwdValid), .enumFwdAddr(enumFwdAddr),
        .chainAddrActive(chainAddrActive), .bottomChainAddr(bottomChainAddr),
        .topChainAddr(topChainAddr), .ownChainAddr(ownChainAddr),
        .addressWriteUnlock(addressWriteUnlock)
    );
    dcar_host_model host_i
    (
        .clk_sys(clk_sys), .enumCmdValid(enumCmdValid), .enumCmdUpPath(enumCmdUpPath),
        .enumCmdAddr(enumCmdAddr), .enumFwdValid(enumFwdValid), .enumFwdAddr(enumFwdAddr)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= dcar_pkg::CHAIN_ADDR_CFG_OFS;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk({15'h0000, regRdValid}, 16'h0001);
        chk(regRdData, exp);
    endtask : rd
    task enum_chk(input logic up, input logic [4:0] a, input logic v, input logic [4:0] f);
        host_i.send(up, a, fwdValid, fwdAddr);
        chk({10'h000, fwdValid, fwdAddr}, {10'h000, v, f});
    endtask : enum_chk
    task por;
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask : por
    task end_of_test;
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        #20000;
        fail_count++;
        end_of_test;
    end
    initial
    begin
        rst_b = 1'b0;
        serialModeSelect = 1'b1;
        softwareResetRequest = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 16'h0000;
        regRdEn = 1'b0;
        por;
        rd(8'h01, 16'h8000);
        chk({15'h0000, addressWriteUnlock}, 16'h0001);
        wr(16'h0000);
        rd(8'h01, 16'h8000);
        wr(16'h7FFF);
        rd(8'h01, 16'hFFE0);
        rd(8'h02, 16'h0000);
        enum_chk(1'b1, 5'h03, 1'b1, 5'h04);
        rd(8'h01, 16'h7FE3);
        enum_chk(1'b0, 5'h1F, 1'b1, 5'h1E);
        rd(8'h01, 16'h7FE3);
        wr(16'h8421);
        enum_chk(1'b0, 5'h05, 1'b1, 5'h04);
        rd(8'h01, 16'h0425);
        chk({chainAddrActive, bottomChainAddr, topChainAddr, ownChainAddr}, 16'h8425);
        chk({15'h0000, addressWriteUnlock}, 16'h0000);
        @(posedge clk_sys);
        softwareResetRequest <= 1'b1;
        @(posedge clk_sys);
        softwareResetRequest <= 1'b0;
        rd(8'h01, 16'h0425);
        @(posedge clk_sys);
        serialModeSelect <= 1'b0;
        #1;
        chk({chainAddrActive, bottomChainAddr, topChainAddr, ownChainAddr}, 16'h0000);
        chk({11'h000, ownChainAddr}, 16'h0000);
        enum_chk(1'b1, 5'h09, 1'b0, 5'h04);
        @(posedge clk_sys);
        serialModeSelect <= 1'b1;
        rd(8'h01, 16'h0425);
        por;
        rd(8'h01, 16'h8000);
        end_of_test;
    end
endmodule : dcar_address_reg_tb_top
